// [rtl/qx_pkg.sv]
// shared constants and types for the quasi-bidirectional port expander
package qx_pkg;

  localparam int          QX_PORT_W      = 8;
  localparam int          QX_SEL_W       = 3;
  // upper four address bits, arbitrary value
  localparam logic [3:0]  QX_ADDR_HI     = 4'h4;
  localparam logic [7:0]  QX_PORT_RESET  = 8'hff;
  localparam logic [3:0]  QX_BYTE_BITS   = 4'h8;
  localparam logic [3:0]  QX_BIT_ZERO    = 4'h0;
  localparam logic [3:0]  QX_BIT_ONE     = 4'h1;

  // alert valid delay: longest time, rounded down to whole cycles
  localparam int          QX_CLK_MHZ          = 100;
  localparam int          QX_ALERT_VALID_NS   = 4000;
  localparam int          QX_ALERT_VALID_CYC  =
    (QX_ALERT_VALID_NS * QX_CLK_MHZ) / 1000;

  // the two serial bus lines travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } qx_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } qx_state_t;

endpackage

// [rtl/qx_sync.sv]
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module qx_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // raw and synchronised levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '1;
      dout   <= '1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule // qx_sync
`default_nettype wire

// [rtl/qx_expander.sv]
// two-wire bus slave with 8-bit quasi-bidirectional port and change alert
`timescale 1ns/1ps
`default_nettype none
module qx_expander
  import qx_pkg::*;
(
  // system
  input  wire logic                 clk,
  input  wire logic                 reset,
  // serial bus pins
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n,
  // address straps
  input  wire logic [QX_SEL_W-1:0]  addr_select,
  // port lines
  input  wire logic [QX_PORT_W-1:0] port_line_in,
  output logic      [QX_PORT_W-1:0] port_line_out,
  output logic      [QX_PORT_W-1:0] port_line_oe_n,
  // change alert, open drain
  output logic                      alert_n_out,
  output logic                      alert_n_oe_n
);

  localparam int AV_CYC = QX_ALERT_VALID_CYC;

  qx_bus_t                bus_raw;
  qx_bus_t                bus_s;
  logic [QX_SEL_W-1:0]    sel_s;
  logic [QX_PORT_W-1:0]   port_s;
  logic                   scl_s;
  logic                   sda_s;
  logic                   scl_d_r;
  logic                   sda_d_r;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start;
  logic                   stop;
  logic                   addr_hit;
  qx_state_t              st_r;
  logic [3:0]             bitcnt_r;
  logic [7:0]             shreg_r;
  logic [7:0]             tx_r;
  logic                   rw_r;
  logic                   ack_r;
  logic [QX_PORT_W-1:0]   port_r;
  logic [QX_PORT_W-1:0]   strong_r;
  logic [QX_PORT_W-1:0]   ref_r;
  logic                   alert_r;
  logic                   clr_rd;
  logic                   clr_wr;
  logic                   clr;
  logic                   mism;
  logic [QX_PORT_W-1:0]   hi_d1_r;
  logic [QX_PORT_W-1:0]   hi_d2_r;

  // every pin is brought into the clk domain first
  assign bus_raw = '{scl: scl_in, sda: sda_in};

  qx_sync #(.W(2)) u_bus_sync (
    .clk   (clk),
    .reset (reset),
    .din   (bus_raw),
    .dout  (bus_s)
  );

  qx_sync #(.W(QX_SEL_W)) u_sel_sync (
    .clk   (clk),
    .reset (reset),
    .din   (addr_select),
    .dout  (sel_s)
  );

  qx_sync #(.W(QX_PORT_W)) u_port_sync (
    .clk   (clk),
    .reset (reset),
    .din   (port_line_in),
    .dout  (port_s)
  );

  assign scl_s = bus_s.scl;
  assign sda_s = bus_s.sda;

  // previous synchronised levels for edge finding
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // edges and bus conditions, all on synchronised lines
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start    = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop     = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // straps fill the low address bits
  assign addr_hit = (shreg_r[7:1] == {QX_ADDR_HI, sel_s});

  // protocol engine: bits are taken on scl rising, data driven on falling,
  // so the device never moves sda while scl is high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r     <= ST_IDLE;
      bitcnt_r <= QX_BIT_ZERO;
      shreg_r  <= 8'h00;
      tx_r     <= 8'h00;
      rw_r     <= 1'b0;
      ack_r    <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (stop) begin
      // stop ends whatever was in progress
      st_r     <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else if (start) begin
      // idle or repeated start: wait for address
      st_r     <= ST_ADDR;
      bitcnt_r <= QX_BIT_ZERO;
      sda_oe_n <= 1'b1;
    end else begin
      case (st_r)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            shreg_r  <= {shreg_r[6:0], sda_s};
            bitcnt_r <= bitcnt_r + QX_BIT_ONE;
          end else if (scl_fall && bitcnt_r == QX_BYTE_BITS) begin
            if (st_r == ST_WR) begin
              // every written byte is acknowledged
              st_r     <= ST_WR_ACK;
              sda_oe_n <= 1'b0;
            end else if (addr_hit) begin
              st_r     <= ST_ADDR_ACK;
              rw_r     <= shreg_r[0];
              sda_oe_n <= 1'b0;
            end else begin
              // other device addressed: sit out until next start
              st_r <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            bitcnt_r <= QX_BIT_ZERO;
            if (st_r == ST_ADDR_ACK && rw_r) begin
              // read: first bit goes out right after the ack
              st_r     <= ST_RD;
              tx_r     <= {port_s[6:0], 1'b0};
              sda_oe_n <= port_s[7];
            end else begin
              st_r     <= ST_WR;
              sda_oe_n <= 1'b1;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bitcnt_r <= bitcnt_r + QX_BIT_ONE;
          end else if (scl_fall) begin
            if (bitcnt_r == QX_BYTE_BITS) begin
              // release for the master's ack bit
              st_r     <= ST_RD_ACK;
              sda_oe_n <= 1'b1;
            end else begin
              sda_oe_n <= tx_r[7];
              tx_r     <= {tx_r[6:0], 1'b0};
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            ack_r <= ~sda_s;
          end else if (scl_fall) begin
            bitcnt_r <= QX_BIT_ZERO;
            if (ack_r) begin
              // acked: fresh port sample for the next byte
              st_r     <= ST_RD;
              tx_r     <= {port_s[6:0], 1'b0};
              sda_oe_n <= port_s[7];
            end else begin
              // nack: keep sda released for the stop
              st_r     <= ST_IDLE;
              sda_oe_n <= 1'b1;
            end
          end
        end
        default: begin
          st_r <= st_r;
        end
      endcase
    end
  end

  // clearing points exist only in states reached by our own address
  assign clr_rd = (st_r == ST_RD_ACK) & scl_rise;
  assign clr_wr = (st_r == ST_WR_ACK) & scl_fall;
  assign clr    = clr_rd | clr_wr;

  // port latch and strong pull-up; lines reset high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_r   <= QX_PORT_RESET;
      strong_r <= '0;
    end else if (clr_wr) begin
      port_r   <= shreg_r;
      strong_r <= shreg_r;
    end else if (scl_fall) begin
      strong_r <= '0;
    end
  end

  // latched levels delayed to line up with port_s: a line just released
  // high is not watched until its new level has come through the sync
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_d1_r <= QX_PORT_RESET;
      hi_d2_r <= QX_PORT_RESET;
    end else begin
      hi_d1_r <= port_line_out;
      hi_d2_r <= hi_d1_r;
    end
  end

  // only lines latched high act as inputs; a line we pull low
  // would otherwise look like a change
  assign mism = |((port_s ^ ref_r) & port_r & hi_d2_r);

  // reference levels: snapshot at each clear, so returning to them
  // drops the alert; a change inside the ack pulse is absorbed
  // lines we were pulling low count as high, their level once released
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_r <= QX_PORT_RESET;
    end else if (clr) begin
      ref_r <= port_s | ~port_r;
    end
  end

  // alert level, renewed on every clock edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= mism & ~clr;
    end
  end

  // pin drivers: low for a 0, strong high briefly, else released
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_line_out  <= QX_PORT_RESET;
      port_line_oe_n <= QX_PORT_RESET;
      alert_n_out    <= 1'b0;
      alert_n_oe_n   <= 1'b1;
      sda_out        <= 1'b0;
    end else begin
      port_line_out  <= port_r;
      port_line_oe_n <= port_r & ~strong_r;
      alert_n_out    <= 1'b0;
      alert_n_oe_n   <= ~alert_r;
      sda_out        <= 1'b0;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_start_seen;
    start |=> (st_r == ST_ADDR) && (bitcnt_r == QX_BIT_ZERO) && sda_oe_n;
  endproperty
  a_start_seen: assert property (p_start_seen)
    else $error("start not followed by address phase");

  property p_stop_seen;
    stop |=> (st_r == ST_IDLE) && sda_oe_n;
  endproperty
  a_stop_seen: assert property (p_stop_seen)
    else $error("stop did not end transfer");

  property p_sda_stable;
    $changed(sda_oe_n) |-> !$past(scl_s) || $past(start) || $past(stop);
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("device moved sda while scl high");

  property p_ack_low;
    ((st_r == ST_WR_ACK) || (st_r == ST_ADDR_ACK)) && scl_rise
      |-> !sda_oe_n ##1 (!sda_oe_n throughout (scl_s [*2]));
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("ack not held low during scl high");

  property p_nack_release;
    (st_r == ST_RD_ACK) && scl_fall && !ack_r && !start && !stop
      |=> sda_oe_n && (st_r == ST_IDLE);
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("sda not released after master nack");

  property p_alert_rise;
    (mism && !clr) ##1 (mism && !clr) |=> !alert_n_oe_n;
  endproperty
  a_alert_rise: assert property (p_alert_rise)
    else $error("input change did not drive alert low");

  property p_alert_bound;
    $rose(mism) ##1 mism [*2] |-> ##[0:AV_CYC] !alert_n_oe_n;
  endproperty
  a_alert_bound: assert property (p_alert_bound)
    else $error("alert later than valid delay");

  property p_rd_clear;
    clr_rd |=> (ref_r == $past(port_s | ~port_r)) && !alert_r;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("read ack did not clear alert");

  property p_wr_clear;
    clr_wr |=> (port_r == $past(shreg_r))
      && (ref_r == $past(port_s | ~port_r)) && !alert_r;
  endproperty
  a_wr_clear: assert property (p_wr_clear)
    else $error("write ack did not latch port and clear alert");

  property p_strong_off;
    (strong_r != '0) && scl_fall && !clr_wr |=> (strong_r == '0);
  endproperty
  a_strong_off: assert property (p_strong_off)
    else $error("strong pull-up outlived scl falling edge");

  property p_ref_only_on_clear;
    $changed(ref_r) |-> $past(clr);
  endproperty
  a_ref_only_on_clear: assert property (p_ref_only_on_clear)
    else $error("alert reference moved outside own access");

  property p_cov_write;
    clr_wr;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_read_more;
    (st_r == ST_RD_ACK) && scl_fall && ack_r;
  endproperty
  c_cov_read_more: cover property (p_cov_read_more);

  property p_cov_alert;
    $fell(alert_n_oe_n) ##[1:1000] $rose(alert_n_oe_n);
  endproperty
  c_cov_alert: cover property (p_cov_alert);

endmodule // qx_expander
`default_nettype wire

// [tb/qx_bus_master.sv]
// behavioural two-wire bus master driving the expander's serial pins
`timescale 1ns/1ps
`default_nettype none
module qx_bus_master #(
  parameter real Q = 31.25
) (
  // system clock, only used to place the first edge of each task
  input  wire logic clk,
  // bus lines: clock push-pull, data open drain with pull-up
  output var  logic scl,
  output var  logic sda_m,
  input  wire logic sda
);
  // both lines released high until the first transfer
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // small offset keeps bus edges clear of system clock edges
  task automatic sync;
    @(negedge clk);
    #2;
  endtask

  // data falls while the clock is high, from an idle bus
  task automatic start;
    sync();
    sda_m = 1'b0;
    #(2*Q);
    scl = 1'b0;
    #Q;
  endtask

  // repeated start without an intervening stop
  task automatic rstart;
    sync();
    sda_m = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_m = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  // data rises while the clock is high
  task automatic stop;
    sync();
    sda_m = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_m = 1'b1;
    #(2*Q);
  endtask

  // one bit: data only moves while the clock is low
  task automatic bit_io(input logic v, output logic r);
    sda_m = v;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  // eight bits msb first, then data released for the ack
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    sync();
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, ack);
  endtask

  // read eight bits; low ack asks for more, high ends the read
  task automatic rd_byte(input logic ack_bit, output logic [7:0] b);
    logic r;
    sync();
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(ack_bit, r);
  endtask
endmodule // qx_bus_master
`default_nettype wire

// [tb/tb_qx_expander.sv]
// self-checking bench for the quasi-bidirectional port expander
`timescale 1ns/1ps
`default_nettype none
module tb_qx_expander;
  import qx_pkg::*;
  localparam logic [2:0] DEV_SEL = 3'h5;
  localparam int         T_MAX   = 20000;
  logic                 clk;
  logic                 reset;
  logic [QX_SEL_W-1:0]  addr_select;
  logic [QX_PORT_W-1:0] port_drv;
  wire logic            scl;
  wire logic            sda_m;
  wire logic            sda;
  wire logic            sda_out;
  wire logic            sda_oe_n;
  wire logic [7:0]      p_in;
  wire logic [7:0]      p_out;
  wire logic [7:0]      p_oe_n;
  wire logic            al_out;
  wire logic            al_oe_n;
  wire logic            alert_w;
  int                   n_errors = 0;
  int                   checks = 0;
  int                   cycles = 0;

  // open-drain wires with pull-ups; ports also see outside pulls
  assign sda     = sda_m & (sda_oe_n | sda_out);
  assign p_in    = port_drv & (p_oe_n | p_out);
  assign alert_w = al_oe_n | al_out;

  qx_bus_master m (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));

  qx_expander dut (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select(addr_select),
    .port_line_in(p_in), .port_line_out(p_out), .port_line_oe_n(p_oe_n),
    .alert_n_out(al_out), .alert_n_oe_n(al_oe_n)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == T_MAX) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // alert must reach the level within its valid delay
  task automatic wait_alert(input logic lvl);
    int n;
    n = 0;
    while (alert_w !== lvl && n < QX_ALERT_VALID_CYC) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, alert_w}, {7'h00, lvl});
  endtask

  task automatic wr1(input logic [7:0] d);
    logic a;
    m.start();
    m.wr_byte({QX_ADDR_HI, DEV_SEL, 1'b0}, a);
    m.wr_byte(d, a);
    m.stop();
  endtask

  task automatic t_reset;
    chk(p_oe_n, 8'hff);
    chk(p_out, 8'hff);
    chk({7'h00, alert_w}, 8'h01);
    chk({7'h00, sda_oe_n}, 8'h01);
  endtask

  // every strap value, matching and neighbouring address
  task automatic t_select;
    logic a;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      addr_select = 3'(i);
      repeat (3) @(negedge clk);
      m.start();
      m.wr_byte({QX_ADDR_HI, 3'(i ^ 1), 1'b0}, a);
      m.stop();
      chk({7'h00, a}, 8'h01);
      m.start();
      m.wr_byte({QX_ADDR_HI, 3'(i), 1'b0}, a);
      m.stop();
      chk({7'h00, a}, 8'h00);
    end
    @(negedge clk);
    addr_select = DEV_SEL;
  endtask

  // multi-byte write, strong pull-up, then read back with ack and nack
  task automatic t_write_read;
    logic       a;
    logic [7:0] d;
    m.start();
    m.wr_byte({QX_ADDR_HI, DEV_SEL, 1'b0}, a);
    chk({7'h00, a}, 8'h00);
    m.wr_byte(8'h3c, a);
    chk({7'h00, a}, 8'h00);
    m.wr_byte(8'ha5, a);
    chk({7'h00, a}, 8'h00);
    m.stop();
    chk(p_out, 8'ha5);
    chk(p_oe_n, 8'h00);
    m.start();
    chk(p_oe_n, 8'ha5);
    m.wr_byte({QX_ADDR_HI, DEV_SEL, 1'b1}, a);
    chk({7'h00, a}, 8'h00);
    m.rd_byte(1'b0, d);
    chk(d, 8'ha5);
    m.rd_byte(1'b1, d);
    chk(d, 8'ha5);
    chk({7'h00, sda_oe_n}, 8'h01);
    m.stop();
    chk({7'h00, alert_w}, 8'h01);
  endtask

  // raise, revert, foreign access, read clear, write clear
  task automatic t_alert;
    logic       a;
    logic [7:0] d;
    wr1(8'hff);
    @(negedge clk);
    port_drv = 8'hef;
    wait_alert(1'b0);
    @(negedge clk);
    port_drv = 8'hff;
    wait_alert(1'b1);
    @(negedge clk);
    port_drv = 8'hfe;
    wait_alert(1'b0);
    m.start();
    m.wr_byte({QX_ADDR_HI, ~DEV_SEL, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    m.wr_byte(8'h00, a);
    chk({7'h00, alert_w}, 8'h00);
    chk(p_out, 8'hff);
    m.rstart();
    m.wr_byte({QX_ADDR_HI, DEV_SEL, 1'b1}, a);
    chk({7'h00, a}, 8'h00);
    m.rd_byte(1'b1, d);
    chk(d, 8'hfe);
    chk({7'h00, alert_w}, 8'h01);
    m.stop();
    @(negedge clk);
    port_drv = 8'hff;
    wait_alert(1'b0);
    wr1(8'hff);
    chk({7'h00, alert_w}, 8'h01);
  endtask

  initial begin
    reset       = 1'b1;
    addr_select = DEV_SEL;
    port_drv    = 8'hff;
    repeat (6) @(negedge clk);
    t_reset();
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_select();
    t_write_read();
    t_alert();
    stop_test();
  end
endmodule // tb_qx_expander
`default_nettype wire
